/* asr_pkg.sv */
// Package and arithmetic unit for the subtract / rotate / set execution datapath.
// Assumes a single clock domain; the arithmetic unit is purely combinational.
// Behaviour
// - Literal-subtract: literal minus working register into working register, five flags updated.
// - File-subtract: file register minus working register, two's complement, five flags updated.
// - Destination bit 0 writes working register, 1 writes back to file register; set-register always writes the file register.
// - Access bit 0 uses access bank; 1 uses bank-select register.
// - Subtract carry means no borrow; negative is sign, zero is zero result.
// - Each instruction runs decode, read, process, write in one four-phase cycle.
// - Rotate right without carry: bit 0 wraps into bit 7; negative and zero updated.
`default_nettype none

package asr_pkg;

   // APB register map (byte addresses)
   localparam logic [11:0] OFS_WORKING = 12'h000;
   localparam logic [11:0] OFS_BANK    = 12'h004;
   localparam logic [11:0] OFS_STATUS  = 12'h008;
   localparam logic [11:0] OFS_INFO    = 12'h00C;

   // Status bit positions
   localparam int FLAG_C  = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z  = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N  = 4;

   // Flag update masks
   localparam logic [4:0] MASK_SUB  = 5'h1F;
   localparam logic [4:0] MASK_NZ   = 5'h14;
   localparam logic [4:0] MASK_NONE = 5'h00;

   // Reset values
   localparam logic [7:0] RST_WORKING = 8'h00;
   localparam logic [3:0] RST_BANK    = 4'h0;
   localparam logic [4:0] RST_STATUS  = 5'h00;

   // Access bank: low half maps to bank 0, high half to bank 15
   localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
   localparam logic [7:0] ALL_ONES       = 8'hFF;

   // Instruction field positions
   localparam int BIT_DEST   = 9;
   localparam int BIT_ACCESS = 8;

   typedef enum logic [2:0] {
      OP_NONE                 = 3'h0,
      OP_SUB_W_FROM_LITERAL   = 3'h1,
      OP_SUB_W_FROM_FILE      = 3'h2,
      OP_ROTATE_RIGHT_NOCARRY = 3'h3,
      OP_SET_FILE_ALL_ONES    = 3'h4
   } asr_op_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEC  = 3'b001,
      ST_RD   = 3'b011,
      ST_PROC = 3'b010,
      ST_WR   = 3'b110
   } asr_state_t;

   function automatic asr_op_t asr_decode(input logic [15:0] iw);
      asr_op_t op;
      op = OP_NONE;
      if (iw[15:8] == 8'h08) begin
         op = OP_SUB_W_FROM_LITERAL;
      end else if (iw[15:10] == 6'b010111) begin
         op = OP_SUB_W_FROM_FILE;
      end else if (iw[15:10] == 6'b010000) begin
         op = OP_ROTATE_RIGHT_NOCARRY;
      end else if (iw[15:9] == 7'b0110100) begin
         op = OP_SET_FILE_ALL_ONES;
      end
      return op;
   endfunction

   // File-register ops read data memory and write it unless the result goes to working register; literal ops do neither
   function automatic logic asr_is_file(input asr_op_t op);
      return (op == OP_SUB_W_FROM_FILE) || (op == OP_ROTATE_RIGHT_NOCARRY) || (op == OP_SET_FILE_ALL_ONES);
   endfunction

endpackage

module asr_alu (
   // Operation select
   input  wire asr_pkg::asr_op_t op,
   // Operands: a is file data or literal, b is working register
   input  wire logic [7:0]       opa,
   input  wire logic [7:0]       opb,
   // Result and flags
   output logic [7:0]            res,
   output logic [4:0]            flags,
   output logic [4:0]            mask
);
   import asr_pkg::*;

   logic [8:0] diff;
   logic [4:0] nib;

   always_comb begin
      // two's complement subtract
      // Subtraction as a + ~b + 1, so carry out is the no-borrow bit
      diff  = {1'b0, opa} + {1'b0, ~opb} + 9'h001;
      nib   = {1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01;
      res   = opa;
      flags = 5'h00;
      mask  = MASK_NONE;
      unique case (op)
         OP_SUB_W_FROM_LITERAL, OP_SUB_W_FROM_FILE: begin
            res            = diff[7:0];
            mask           = MASK_SUB;
            flags[FLAG_C]  = diff[8];
            flags[FLAG_DC] = nib[4];
            flags[FLAG_OV] = (opa[7] != opb[7]) && (diff[7] != opa[7]);
         end
         OP_ROTATE_RIGHT_NOCARRY: begin
            // wrap bit 0 into bit 7
            res  = {opa[0], opa[7:1]};
            mask = MASK_NZ;
         end
         OP_SET_FILE_ALL_ONES: begin
            res = ALL_ONES;
         end
         OP_NONE: begin
            res = opa;
         end
      endcase
      flags[FLAG_Z] = (res == 8'h00);
      flags[FLAG_N] = res[7];
   end

endmodule

`default_nettype wire

/* asr_core.sv */
// Execution datapath for literal-subtract, file-subtract, rotate-right and set-register.
// Assumes the data memory returns read data one clock after mem_rd_en and writes on mem_wr_en.
`default_nettype none

module asr_core (
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Instruction from decoder
   input  wire logic        instr_valid,
   input  wire logic [15:0] instr_word,
   output logic             instr_ready,
   // Banked data memory
   output logic      [11:0] mem_addr,
   output logic             mem_rd_en,
   output logic             mem_wr_en,
   output logic      [7:0]  mem_wdata,
   input  wire logic [7:0]  mem_rdata
);
   import asr_pkg::*;

   asr_state_t  st_q,      st_d;
   logic [15:0] instr_q,   instr_d;
   logic [11:0] addr_q,    addr_d;
   logic [7:0]  result_q,  result_d;
   logic [4:0]  aflags_q,  aflags_d;
   logic [7:0]  working_q, working_d;
   logic [3:0]  bank_q,    bank_d;
   logic [4:0]  status_q,  status_d;
   logic [31:0] prdata_q,  prdata_d;

   asr_op_t     op;
   logic        file_op;
   logic        to_working;
   logic [7:0]  alu_a;
   logic [7:0]  alu_res;
   logic [4:0]  alu_flags;
   logic [4:0]  alu_mask;
   logic        apb_wr;
   logic        apb_setup;
   logic        mapped;

   assign op         = asr_decode(instr_q);
   assign file_op    = asr_is_file(op);
   // destination bit selects working register when clear
   assign to_working = (op == OP_SUB_W_FROM_LITERAL) ||
                       ((op == OP_SUB_W_FROM_FILE || op == OP_ROTATE_RIGHT_NOCARRY) && !instr_q[BIT_DEST]);
   assign alu_a      = (op == OP_SUB_W_FROM_LITERAL) ? instr_q[7:0] : mem_rdata;

   asr_alu u_alu (
      .op    (op),
      .opa   (alu_a),
      .opb   (working_q),
      .res   (alu_res),
      .flags (alu_flags),
      .mask  (alu_mask)
   );

   assign apb_wr    = psel && penable && pwrite;
   assign apb_setup = psel && !penable;
   assign mapped    = (paddr == OFS_WORKING) || (paddr == OFS_BANK) ||
                      (paddr == OFS_STATUS)  || (paddr == OFS_INFO);

   assign pready      = psel && penable;
   assign pslverr     = pready && !mapped;
   assign prdata      = prdata_q;
   assign instr_ready = (st_q == ST_IDLE) || (st_q == ST_WR);
   assign mem_addr    = addr_q;
   assign mem_wdata   = result_q;
   assign mem_rd_en   = (st_q == ST_RD) && file_op;
   // write back to file register when destination bit set, and always for set-register
   assign mem_wr_en   = (st_q == ST_WR) && file_op && !to_working;

   always_comb begin
      st_d      = st_q;
      instr_d   = instr_q;
      addr_d    = addr_q;
      result_d  = result_q;
      aflags_d  = aflags_q;
      working_d = working_q;
      bank_d    = bank_q;
      status_d  = status_q;
      prdata_d  = prdata_q;

      // Read data captured in setup so the access phase answers from a flop
      if (apb_setup) begin
         prdata_d = 32'h0000_0000;
         unique case (paddr)
            OFS_WORKING: prdata_d[7:0] = working_q;
            OFS_BANK:    prdata_d[3:0] = bank_q;
            OFS_STATUS:  prdata_d[4:0] = status_q;
            OFS_INFO:    prdata_d[3:0] = {op, st_q != ST_IDLE};
            default:     prdata_d      = 32'h0000_0000;
         endcase
      end
      // Software writes first, so a same-cycle datapath write wins
      if (apb_wr) begin
         unique case (paddr)
            OFS_WORKING: working_d = pwdata[7:0];
            OFS_BANK:    bank_d    = pwdata[3:0];
            OFS_STATUS:  status_d  = pwdata[4:0];
            default:     working_d = working_q;
         endcase
      end

      unique case (st_q)
         ST_IDLE: begin
            if (instr_valid) begin
               instr_d = instr_word;
               st_d    = ST_DEC;
            end
         end
         ST_DEC: begin
            if (instr_q[BIT_ACCESS]) begin
               addr_d = {bank_q, instr_q[7:0]};
            end else begin
               addr_d = {instr_q[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK, instr_q[7:0]};
            end
            st_d = ST_RD;
         end
         ST_RD: begin
            st_d = ST_PROC;
         end
         ST_PROC: begin
            result_d = alu_res;
            aflags_d = alu_flags;
            st_d     = ST_WR;
         end
         ST_WR: begin
            // result into working register when to_working, and flags updated under alu_mask
            if (to_working) begin
               working_d = result_q;
            end
            status_d = (status_d & ~alu_mask) | (aflags_q & alu_mask);
            if (instr_valid) begin
               instr_d = instr_word;
               st_d    = ST_DEC;
            end else begin
               st_d = ST_IDLE;
            end
         end
         default: begin
            st_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= ST_IDLE;
         instr_q   <= 16'h0000;
         addr_q    <= 12'h000;
         result_q  <= 8'h00;
         aflags_q  <= 5'h00;
         working_q <= RST_WORKING;
         bank_q    <= RST_BANK;
         status_q  <= RST_STATUS;
         prdata_q  <= 32'h0000_0000;
      end else begin
         st_q      <= st_d;
         instr_q   <= instr_d;
         addr_q    <= addr_d;
         result_q  <= result_d;
         aflags_q  <= aflags_d;
         working_q <= working_d;
         bank_q    <= bank_d;
         status_q  <= status_d;
         prdata_q  <= prdata_d;
      end
   end

   lit_sub_result_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_PROC && op == OP_SUB_W_FROM_LITERAL) |-> ##2
      working_q == 8'($past(instr_q[7:0], 2) - $past(working_q, 2)))
      else $error("literal subtract result wrong");

   file_sub_result_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_PROC && op == OP_SUB_W_FROM_FILE) |-> ##1
      (mem_wr_en || to_working) && result_q == 8'($past(mem_rdata) - $past(working_q)))
      else $error("file subtract result wrong");

   dest_select_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_WR && (op == OP_SUB_W_FROM_FILE || op == OP_ROTATE_RIGHT_NOCARRY)) |->
      (mem_wr_en == instr_q[BIT_DEST]))
      else $error("destination select wrong");

   bank_select_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_RD && file_op) |-> mem_rd_en && mem_addr[7:0] == instr_q[7:0] &&
      mem_addr[11:8] == (instr_q[BIT_ACCESS] ? bank_q : {4{instr_q[7]}}))
      else $error("bank selection wrong");

   sub_flags_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_PROC && op == OP_SUB_W_FROM_FILE && !apb_wr) |-> ##2
      status_q[FLAG_C] == ($past(mem_rdata, 2) >= $past(working_q, 2)) &&
      status_q[FLAG_N] == $past(result_q) >> 7 && status_q[FLAG_Z] == ($past(result_q) == 8'h00))
      else $error("subtract flags wrong");

   four_phase_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (instr_valid && instr_ready) |=> st_q == ST_DEC ##1 st_q == ST_RD ##1 st_q == ST_PROC ##1 st_q == ST_WR)
      else $error("phase sequence wrong");

   rotate_right_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_PROC && op == OP_ROTATE_RIGHT_NOCARRY) |=>
      result_q == {$past(mem_rdata[0]), $past(mem_rdata[7:1])} && aflags_q[FLAG_N] == $past(mem_rdata[0]))
      else $error("rotate result wrong");

   set_ones_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      (st_q == ST_WR && op == OP_SET_FILE_ALL_ONES && !apb_wr) |-> mem_wr_en && mem_wdata == ALL_ONES ##1
      status_q == $past(status_q))
      else $error("set register wrong");

endmodule

`default_nettype wire

/* asr_mem_model.sv */
// Partner model of the banked data memory: 4096 bytes behind a 12-bit address.
// Assumes the datapath pulses mem_rd_en for one cycle and wants the data in the next cycle.
`default_nettype none
module asr_mem_model (
   // Clock
   input  wire logic        pclk,
   // Datapath side
   input  wire logic [11:0] mem_addr,
   input  wire logic        mem_rd_en,
   input  wire logic        mem_wr_en,
   input  wire logic [7:0]  mem_wdata,
   output logic      [7:0]  mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] mem [4096];

   always @(posedge pclk) begin
      if (mem_wr_en) begin
         mem[mem_addr] <= mem_wdata;
      end
      // Outside the read slot the bus toggles, so stale data cannot pass for a read
      mem_rdata <= mem_rd_en ? mem[mem_addr] : ~mem_rdata;
   end
endmodule
`default_nettype wire

/* alu_subtract_rotate_set_tb.sv */
// Testbench for asr_core: APB register access and instruction runs against a memory model.
// Assumes asr_mem_model as the far side and one 100 MHz clock.
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module alu_subtract_rotate_set_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import asr_pkg::*;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic        instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic [31:0] prdata;
   logic        pready, pslverr, instr_ready, mem_rd_en, mem_wr_en;
   logic [11:0] mem_addr;
   logic [7:0]  mem_wdata, mem_rdata;
   int          fails = 0;
   int          checks_done = 0;
   int          lowc;

   always #5 pclk = ~pclk;

   asr_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
      .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata),
      .mem_rdata(mem_rdata));

   asr_mem_model u_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_rd_en(mem_rd_en),
      .mem_wr_en(mem_wr_en), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   task automatic summarize();
      if (fails == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // One APB transfer; entered just after a rising edge, leaves one idle cycle behind
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Only the watchdog ends a wait for pready
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, q, e);
      `CHK(nm, x, q)
   endtask

   // Offers one instruction and returns after the edge that ends its write phase
   task automatic run(input logic [15:0] iw);
      instr_valid <= 1'b1;
      instr_word <= iw;
      @(negedge pclk);
      `CHK("instr_ready idle", 1'b1, instr_ready)
      @(posedge pclk);
      instr_valid <= 1'b0;
      lowc = 0;
      @(negedge pclk);
      while (instr_ready !== 1'b1 && lowc < 20) begin
         lowc++;
         @(negedge pclk);
      end
      @(posedge pclk);
      `CHK("busy phases", 3, lowc)
   endtask

   // Subtract flags a - b as {N, OV, Z, DC, C}; carry means no borrow
   function automatic logic [4:0] sflags(input logic [7:0] a, input logic [7:0] b);
      logic [7:0] r;
      r = a - b;
      return {r[7], (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] >= b[3:0], a >= b};
   endfunction

   initial begin
      #50us;
      fails++;
      summarize();
   end

   initial begin
      logic [7:0]  lk [4] = '{8'h02, 8'h02, 8'h02, 8'h10};
      logic [7:0]  lw [4] = '{8'h01, 8'h02, 8'h03, 8'h90};
      // Fields: instruction, bank select, memory byte, working register
      logic [35:0] tc [7] = '{36'h5_E205_0302, 36'h5_C905_0202, 36'h5_F205_0102, 36'h4_2203_D700,
                              36'h4_1443_D711, 36'h6_9443_0011, 36'h6_8103_5A11};
      logic [15:0] iw;
      logic [3:0]  bk;
      logic [7:0]  m, w, f, r;
      logic [11:0] ad;
      logic [4:0]  st;
      logic        dst, e;
      logic [31:0] q;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk("working reset", OFS_WORKING, 32'h0000_0000);
      rdchk("bank reset", OFS_BANK, 32'h0000_0000);
      rdchk("status reset", OFS_STATUS, 32'h0000_0000);
      rdchk("info reset", OFS_INFO, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000, q, e);
      `CHK("unmapped error", 1'b1, e)
      `CHK("unmapped data", 32'h0000_0000, q)
      for (int i = 0; i < 4; i++) begin
         wr(OFS_WORKING, {24'h00_0000, lw[i]});
         run({8'h08, lk[i]});
         rdchk("literal result", OFS_WORKING, {24'h00_0000, 8'(lk[i] - lw[i])});
         rdchk("literal flags", OFS_STATUS, {27'h000_0000, sflags(lk[i], lw[i])});
      end
      for (int i = 0; i < 7; i++) begin
         {iw, bk, m, w} = tc[i];
         f = iw[7:0];
         ad = iw[8] ? {bk, f} : {(f[7] ? 4'hF : 4'h0), f};
         u_mem.mem[ad] = m;
         wr(OFS_BANK, {28'h000_0000, bk});
         wr(OFS_WORKING, {24'h00_0000, w});
         wr(OFS_STATUS, 32'h0000_000F);
         if (iw[15:10] == 6'b010111) begin
            r = m - w;
            st = sflags(m, w);
         end else if (iw[15:10] == 6'b010000) begin
            r = {m[0], m[7:1]};
            st = {r[7], 1'b1, r == 8'h00, 2'b11};
         end else begin
            r = 8'hFF;
            st = 5'h0F;
         end
         dst = iw[9] | (iw[15:10] == 6'b011010);
         run(iw);
         rdchk("working after op", OFS_WORKING, {24'h00_0000, (dst ? w : r)});
         // Memory is looked at only after the write edge has settled
         `CHK("file data", (dst ? r : m), u_mem.mem[ad])
         rdchk("flags after op", OFS_STATUS, {27'h000_0000, st});
      end
      // Last op was set-register, now idle: op code 4 in bits 3:1
      rdchk("info last op", OFS_INFO, 32'h0000_0008);
      // Unknown opcode still takes four phases and changes nothing
      run(16'hFFFF);
      rdchk("working after no-op", OFS_WORKING, 32'h0000_0011);
      rdchk("flags after no-op", OFS_STATUS, 32'h0000_000F);
      summarize();
   end
endmodule
`default_nettype wire
